/* mpb_consts.svh */
// Constants for the multi-port concurrent access self-test block
// Operation
// - Concurrent read returns reference, column or row data
// - Concurrent read only for two-logical-port test port
// - Strobe same cycle async, next cycle sync
// - Concurrent write only 2RW, 1R1W, nR2W memories
// - Write enable off idles, on targets selected cell
// - Automatic write enable follows write address selects
// - Polarity control can invert concurrent write data
// - Column select flips column LSB, else row LSB
// - Select off leaves test address unmodified
// - Automatic selects off first cycle, then hold
// - Column select needs read enable and support
// - Row select flips row LSB on read
// - Row select ignored without rows or support
// - No concurrent read on ROM or 1RW
// - Write row select flips row LSB, enables write
// - Write column select flips column LSB, enables write
// - Write settings usable in any operation cycle
// - All changes synchronous to self-test clock
// - Polarity: data or complement, automatic holds
`ifndef MPB_CONSTS_SVH
`define MPB_CONSTS_SVH
// ==========================================================
// Array geometry
`define MPB_ROW_W 6
`define MPB_COL_W 3
`define MPB_ADDR_W 9
`define MPB_DATA_W 16
`define MPB_ROW_LSB 3
`define MPB_COL_LSB 0
// ==========================================================
// Per-cycle setting codes
`define MPB_SET_AUTO 2'h0
`define MPB_SET_OFF 2'h1
`define MPB_SET_ON 2'h2
// ==========================================================
// Memory type codes
`define MPB_MT_ROM 3'h0
`define MPB_MT_1RW 3'h1
`define MPB_MT_2RW 3'h2
`define MPB_MT_1R1W 3'h3
`define MPB_MT_NR2W 3'h4
// ==========================================================
// Register map and fields
`define MPB_AXI_AW 8
`define MPB_OFS_CTRL 8'h00
`define MPB_OFS_CFG 8'h04
`define MPB_OFS_STAT 8'h08
`define MPB_CTRL_RST 32'h0000_0000
`define MPB_CFG_RST 32'h0000_0000
`define MPB_CTRL_EN 0
`define MPB_CFG_TYPE_LSB 0
`define MPB_CFG_TYPE_MSB 2
`define MPB_CFG_HASCOL 3
`define MPB_CFG_HASROW 4
`define MPB_CFG_PARRD 5
`define MPB_CFG_TWOLP 6
`define MPB_CFG_SYNCRD 7
`define MPB_STAT_FAIL 0
`define MPB_STAT_ACT 1
`define MPB_RESP_OKAY 2'h0
`define MPB_RESP_SLVERR 2'h2
`endif

/* mpb_pkg.sv */
// Types shared by the concurrent access self-test block
`include "mpb_consts.svh"
package mpb_pkg;
    // ======================================================
    // Per-cycle concurrent settings, each an auto/off/on code
    typedef struct packed {
        logic [1:0] rd_en;
        logic [1:0] wr_en;
        logic [1:0] rd_col;
        logic [1:0] rd_row;
        logic [1:0] wr_row;
        logic [1:0] wr_col;
        logic [1:0] wr_pol;
    } mpb_sel_type;
    // ======================================================
    // One sequencer cycle
    typedef struct packed {
        logic                      op_active;
        logic                      first_cycle;
        logic                      strobe;
        mpb_sel_type               sel;
        logic [`MPB_ROW_W-1:0]     row;
        logic [`MPB_COL_W-1:0]     col;
        logic [`MPB_DATA_W-1:0]    wdata;
        logic [`MPB_DATA_W-1:0]    expect_data;
    } mpb_cyc_type;
    // ======================================================
    // Inactive memory port
    typedef struct packed {
        logic [`MPB_ADDR_W-1:0]    addr;
        logic [`MPB_DATA_W-1:0]    wdata;
        logic                      we;
        logic                      re;
    } mpb_port_type;
endpackage

/* mpb_top.sv */
// Concurrent access control for the inactive port of a multi-port memory
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
`include "mpb_consts.svh"
module mpb_top (
    input  wire logic                     clk_i,
    input  wire logic                     nrst_i,
    input  wire logic [`MPB_AXI_AW-1:0]   s_axi_awaddr_i,
    input  wire logic                     s_axi_awvalid_i,
    output logic                          s_axi_awready_o,
    input  wire logic [31:0]              s_axi_wdata_i,
    input  wire logic [3:0]               s_axi_wstrb_i,
    input  wire logic                     s_axi_wvalid_i,
    output logic                          s_axi_wready_o,
    output logic [1:0]                    s_axi_bresp_o,
    output logic                          s_axi_bvalid_o,
    input  wire logic                     s_axi_bready_i,
    input  wire logic [`MPB_AXI_AW-1:0]   s_axi_araddr_i,
    input  wire logic                     s_axi_arvalid_i,
    output logic                          s_axi_arready_o,
    output logic [31:0]                   s_axi_rdata_o,
    output logic [1:0]                    s_axi_rresp_o,
    output logic                          s_axi_rvalid_o,
    input  wire logic                     s_axi_rready_i,
    input  wire mpb_pkg::mpb_cyc_type     cyc_i,
    input  wire mpb_pkg::mpb_port_type    func_i,
    input  wire logic [`MPB_DATA_W-1:0]   mem_q_i,
    output mpb_pkg::mpb_port_type         port_o,
    output logic                          cmp_strobe_o,
    output logic                          cmp_fail_o
);
    // ======================================================
    // Reset synchroniser
    logic rst_meta_reg;
    logic rst_n;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ======================================================
    // Helpers
    // Auto keeps the last resolved value, but off on the first cycle
    function automatic logic resolve(input logic [1:0] code,
                                     input logic first, input logic prev);
        if (code == `MPB_SET_ON)
            resolve = 1'b1;
        else if (code == `MPB_SET_OFF)
            resolve = 1'b0;
        else
            resolve = first ? 1'b0 : prev;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        end
        merge = r;
    endfunction

    // ======================================================
    // Register state
    logic [31:0] ctrl_reg;
    logic [31:0] cfg_reg;
    logic        fail_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [`MPB_AXI_AW-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_go;
    logic        fail_clr;
    logic        miss;
    logic [2:0]  mtype;
    logic        en;
    logic        has_col;
    logic        has_row;
    logic        sync_rd;

    assign mtype   = cfg_reg[`MPB_CFG_TYPE_MSB:`MPB_CFG_TYPE_LSB];
    assign en      = ctrl_reg[`MPB_CTRL_EN];
    assign has_col = cfg_reg[`MPB_CFG_HASCOL];
    assign has_row = cfg_reg[`MPB_CFG_HASROW];
    assign sync_rd = cfg_reg[`MPB_CFG_SYNCRD];
    assign wr_go   = aw_got_reg & w_got_reg & ~s_axi_bvalid_o;
    assign fail_clr = wr_go & (waddr_reg == `MPB_OFS_STAT)
                    & wstrb_reg[0] & wdata_reg[`MPB_STAT_FAIL];

    // ======================================================
    // AXI write channel: address and data in either order
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            aw_got_reg      <= 1'b0;
            w_got_reg       <= 1'b0;
            waddr_reg       <= '0;
            wdata_reg       <= '0;
            wstrb_reg       <= '0;
            s_axi_bvalid_o  <= 1'b0;
            s_axi_bresp_o   <= `MPB_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                s_axi_awready_o <= 1'b0;
                aw_got_reg      <= 1'b1;
                waddr_reg       <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                s_axi_wready_o <= 1'b0;
                w_got_reg      <= 1'b1;
                wdata_reg      <= s_axi_wdata_i;
                wstrb_reg      <= s_axi_wstrb_i;
            end
            if (wr_go) begin
                aw_got_reg     <= 1'b0;
                w_got_reg      <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                if (waddr_reg == `MPB_OFS_CTRL || waddr_reg == `MPB_OFS_CFG
                    || waddr_reg == `MPB_OFS_STAT)
                    s_axi_bresp_o <= `MPB_RESP_OKAY;
                else
                    s_axi_bresp_o <= `MPB_RESP_SLVERR;
            end
            // Ready returns only after the response, one write at a time
            if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o  <= 1'b0;
                s_axi_awready_o <= 1'b1;
                s_axi_wready_o  <= 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `MPB_CTRL_RST;
            cfg_reg  <= `MPB_CFG_RST;
        end else if (wr_go) begin
            if (waddr_reg == `MPB_OFS_CTRL)
                ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
            else if (waddr_reg == `MPB_OFS_CFG)
                cfg_reg <= merge(cfg_reg, wdata_reg, wstrb_reg);
        end
    end

    // Sticky compare failure; a new miss beats a clear
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            fail_reg <= 1'b0;
        else if (miss)
            fail_reg <= 1'b1;
        else if (fail_clr)
            fail_reg <= 1'b0;
    end

    // ======================================================
    // AXI read channel
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o  <= 1'b0;
            s_axi_rdata_o   <= '0;
            s_axi_rresp_o   <= `MPB_RESP_OKAY;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o  <= 1'b1;
            s_axi_rresp_o   <= `MPB_RESP_OKAY;
            if (s_axi_araddr_i == `MPB_OFS_CTRL)
                s_axi_rdata_o <= ctrl_reg;
            else if (s_axi_araddr_i == `MPB_OFS_CFG)
                s_axi_rdata_o <= cfg_reg;
            else if (s_axi_araddr_i == `MPB_OFS_STAT)
                s_axi_rdata_o <= {30'h0, cyc_i.op_active, fail_reg};
            else begin
                s_axi_rdata_o <= '0;
                s_axi_rresp_o <= `MPB_RESP_SLVERR;
            end
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o  <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // ======================================================
    // Per-cycle resolution of the concurrent settings
    logic rd_en_h, rd_col_h, rd_row_h, wr_row_h, wr_col_h, pol_h;
    logic rd_en_c, rd_col_c, rd_row_c, wr_row_c, wr_col_c, pol_c, wr_en_c;
    logic rd_ok, wr_ok, act, conc_rd, conc_wr;
    logic flip_rd_row, flip_rd_col;
    logic [`MPB_ROW_W-1:0] rd_row, wr_row;
    logic [`MPB_COL_W-1:0] rd_col, wr_col;

    always_comb begin
        rd_en_c  = resolve(cyc_i.sel.rd_en, cyc_i.first_cycle, rd_en_h);
        rd_col_c = resolve(cyc_i.sel.rd_col, cyc_i.first_cycle, rd_col_h);
        rd_row_c = resolve(cyc_i.sel.rd_row, cyc_i.first_cycle, rd_row_h);
        wr_row_c = resolve(cyc_i.sel.wr_row, cyc_i.first_cycle, wr_row_h);
        wr_col_c = resolve(cyc_i.sel.wr_col, cyc_i.first_cycle, wr_col_h);
        pol_c    = resolve(cyc_i.sel.wr_pol, cyc_i.first_cycle, pol_h);
        // With write enable on auto, either write select turns the write on; off always wins
        if (cyc_i.sel.wr_en == `MPB_SET_ON)
            wr_en_c = 1'b1;
        else if (cyc_i.sel.wr_en == `MPB_SET_OFF)
            wr_en_c = 1'b0;
        else
            wr_en_c = wr_row_c | wr_col_c;
    end

    // Held values for the next cycle of the operation
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_en_h  <= 1'b0;
            rd_col_h <= 1'b0;
            rd_row_h <= 1'b0;
            wr_row_h <= 1'b0;
            wr_col_h <= 1'b0;
            pol_h    <= 1'b0;
        end else if (cyc_i.op_active) begin
            rd_en_h  <= rd_en_c;
            rd_col_h <= rd_col_c;
            rd_row_h <= rd_row_c;
            wr_row_h <= wr_row_c;
            wr_col_h <= wr_col_c;
            pol_h    <= pol_c;
        end
    end

    // Which memories may see concurrent traffic at all
    assign rd_ok = cfg_reg[`MPB_CFG_PARRD] & cfg_reg[`MPB_CFG_TWOLP]
                 & (mtype != `MPB_MT_ROM) & (mtype != `MPB_MT_1RW);
    assign wr_ok = (mtype == `MPB_MT_2RW) | (mtype == `MPB_MT_1R1W)
                 | (mtype == `MPB_MT_NR2W);
    assign act     = en & cyc_i.op_active;
    assign conc_rd = act & rd_ok & rd_en_c;
    assign conc_wr = act & wr_ok & wr_en_c;
    // Without columns the column select falls back to the row bit
    assign flip_rd_col = rd_col_c & has_col;
    assign flip_rd_row = (rd_row_c & has_row) | (rd_col_c & ~has_col);
    assign rd_row = cyc_i.row ^ {{(`MPB_ROW_W-1){1'b0}}, flip_rd_row};
    assign rd_col = cyc_i.col ^ {{(`MPB_COL_W-1){1'b0}}, flip_rd_col};
    assign wr_row = cyc_i.row ^ {{(`MPB_ROW_W-1){1'b0}}, wr_row_c};
    assign wr_col = cyc_i.col ^ {{(`MPB_COL_W-1){1'b0}}, wr_col_c};

    // ======================================================
    // Inactive port drive; a write takes the port over a read
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            port_o <= '0;
        end else if (!en) begin
            port_o <= func_i;
        end else if (conc_wr) begin
            port_o.addr  <= {wr_row, wr_col};
            port_o.wdata <= pol_c ? ~cyc_i.wdata : cyc_i.wdata;
            port_o.we    <= 1'b1;
            port_o.re    <= 1'b0;
        end else if (conc_rd) begin
            port_o.addr  <= {rd_row, rd_col};
            port_o.wdata <= cyc_i.wdata;
            port_o.we    <= 1'b0;
            port_o.re    <= 1'b1;
        end else begin
            port_o.addr  <= {cyc_i.row, cyc_i.col};
            port_o.wdata <= cyc_i.wdata;
            port_o.we    <= 1'b0;
            port_o.re    <= 1'b0;
        end
    end

    // ======================================================
    // Compare of concurrent read data
    logic rd_live_reg, rd_d2_reg;
    logic [`MPB_DATA_W-1:0] exp_live_reg, exp_d2_reg;
    logic strobe_now;
    logic [`MPB_DATA_W-1:0] exp_now;

    // Sync ports deliver data one cycle after the address
    assign strobe_now = sync_rd ? rd_d2_reg : rd_live_reg;
    assign exp_now    = sync_rd ? exp_d2_reg : exp_live_reg;
    assign miss       = strobe_now & (mem_q_i != exp_now);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rd_live_reg  <= 1'b0;
            rd_d2_reg    <= 1'b0;
            exp_live_reg <= '0;
            exp_d2_reg   <= '0;
            cmp_strobe_o <= 1'b0;
            cmp_fail_o   <= 1'b0;
        end else begin
            rd_live_reg  <= conc_rd & ~conc_wr & cyc_i.strobe;
            rd_d2_reg    <= rd_live_reg;
            exp_live_reg <= cyc_i.expect_data;
            exp_d2_reg   <= exp_live_reg;
            cmp_strobe_o <= strobe_now;
            cmp_fail_o   <= miss;
        end
    end

    // ======================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    AST_PASS_THRU: assert property (!en |=> port_o == $past(func_i))
        else $error("functional port not passed through");
    AST_NO_RD_TYPE: assert property (en && !rd_ok |=> !port_o.re)
        else $error("concurrent read on unsupported memory");
    AST_NO_WR_TYPE: assert property (en && !wr_ok |=> !port_o.we)
        else $error("concurrent write on unsupported memory");
    AST_FIRST_AUTO: assert property (act && cyc_i.first_cycle
        && cyc_i.sel.wr_en == `MPB_SET_AUTO && cyc_i.sel.wr_row == `MPB_SET_AUTO
        && cyc_i.sel.wr_col == `MPB_SET_AUTO |=> !port_o.we)
        else $error("auto write select not off in first cycle");
    AST_RD_COL: assert property (conc_rd && !conc_wr && rd_col_c && has_col
        |=> port_o.addr[`MPB_COL_LSB] != $past(cyc_i.col[0]))
        else $error("read column bit not inverted");
    AST_RD_ROW: assert property (conc_rd && !conc_wr && rd_row_c && has_row
        && !(rd_col_c && !has_col)
        |=> port_o.addr[`MPB_ROW_LSB] != $past(cyc_i.row[0]))
        else $error("read row bit not inverted");
    AST_WR_ROW: assert property (act && wr_ok && cyc_i.sel.wr_row == `MPB_SET_ON
        && cyc_i.sel.wr_en != `MPB_SET_OFF
        |=> port_o.we && port_o.addr[`MPB_ROW_LSB] != $past(cyc_i.row[0]))
        else $error("write row select did not write adjacent row");
    AST_WR_COL: assert property (act && wr_ok && cyc_i.sel.wr_col == `MPB_SET_ON
        && cyc_i.sel.wr_en != `MPB_SET_OFF
        |=> port_o.we && port_o.addr[`MPB_COL_LSB] != $past(cyc_i.col[0]))
        else $error("write column select did not write adjacent column");
    AST_WR_OFF: assert property (en && cyc_i.sel.wr_en == `MPB_SET_OFF
        |=> !port_o.we)
        else $error("write active while explicitly off");
    AST_POL: assert property (conc_wr && pol_c
        |=> port_o.wdata == ~$past(cyc_i.wdata))
        else $error("write data not inverted");
    AST_SEL_OFF: assert property (act && !conc_wr && !conc_rd
        |=> port_o.addr == {$past(cyc_i.row), $past(cyc_i.col)})
        else $error("address modified without select");
    AST_STROBE_SYNC: assert property (sync_rd && rd_live_reg && $stable(sync_rd)
        |-> ##2 cmp_strobe_o)
        else $error("sync strobe not one cycle late");
    AST_STROBE_ASYNC: assert property (!sync_rd && rd_live_reg |=> cmp_strobe_o)
        else $error("async strobe not in read cycle");

    COV_CONC_RD: cover property (conc_rd && !conc_wr ##1 port_o.re);
    COV_DIAG_WR: cover property (conc_wr && wr_row_c && wr_col_c);
    COV_INV_WR: cover property (conc_wr && pol_c && !cyc_i.first_cycle);
    COV_FAIL: cover property (cmp_strobe_o && cmp_fail_o);
endmodule

/* mpb_mem_model.sv */
// Behavioural inactive-port memory that faces the concurrent access block
`include "mpb_consts.svh"
module mpb_mem_model (
    input  wire logic                   clk_i,
    input  wire mpb_pkg::mpb_port_type  port_i,
    input  wire logic                   sync_i,
    output logic [`MPB_DATA_W-1:0]      q_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [`MPB_DATA_W-1:0] mem [0:511];
    logic [`MPB_DATA_W-1:0] qs = 16'h0000;
    // ======================================================
    // Array with a fixed, address-dependent start pattern
    initial for (int i = 0; i < 512; i++) mem[i] = 16'(i * 16'h0F1D) ^ 16'hA5C3;
    // Write port, and a registered read that decays when idle so stale data never matches
    always @(posedge clk_i) begin
        if (port_i.we) mem[port_i.addr] <= port_i.wdata;
        qs <= port_i.re ? mem[port_i.addr] : ~qs;
    end
    // Asynchronous ports show the array straight through while read is asked
    assign q_o = sync_i ? qs : (port_i.re ? mem[port_i.addr] : ~qs);
endmodule

/* mpb_top_tb_top.sv */
// Self-checking bench for the concurrent access block, with a reference model
`include "mpb_consts.svh"
module mpb_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ======================================================
    // Stimulus, design outputs and model state
    logic                  clk_i = 0, nrst_i = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic [7:0]            awa = 0, ara = 0;
    logic [31:0]           wdt = 0, rdt;
    logic                  awr, wr, bv, arr, rv, cs, cf;
    logic [1:0]            br, rr;
    logic [15:0]           q;
    mpb_pkg::mpb_cyc_type  cyc = '0;
    mpb_pkg::mpb_port_type func = '0, pt, ep = '0;
    logic [15:0]           sh [0:511];
    logic [6:0]            hold = 0, v;
    logic [13:0]           cd;
    logic [8:0]            a;
    logic [2:0]            typ = 0;
    logic                  en_m = 0, mdl = 0, vld = 0, pe = 1, stk = 0, os, of, cw, cr, wen, okt;
    logic                  d1s = 0, d1f = 0, d2s = 0, d2f = 0, hcol = 0, hrow = 0;
    logic                  prd = 0, tlp = 0, syn = 0;
    int                    fail_count = 0, checked = 0;
    mpb_top mpb_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awa),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdt),
        .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
        .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdt), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv),
        .s_axi_rready_i(rry), .cyc_i(cyc), .func_i(func), .mem_q_i(q), .port_o(pt),
        .cmp_strobe_o(cs), .cmp_fail_o(cf));
    mpb_mem_model mpb_mem_model_i (.clk_i(clk_i), .port_i(pt), .sync_i(syn), .q_o(q));
    always #12.5 clk_i = ~clk_i;
    // ======================================================
    // Checking and bus tasks
    task results;
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cmp_v(input logic [31:0] g, input logic [31:0] e, input string m);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] r);
        logic ok_a, ok_d;
        ok_a = 0;
        ok_d = 0;
        @(posedge clk_i);
        awa <= ad;
        wdt <= dt;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        while (!(ok_a && ok_d)) begin
            @(posedge clk_i);
            if (awv && awr) ok_a = 1;
            if (awv && awr) awv <= 0;
            if (wv && wr) ok_d = 1;
            if (wv && wr) wv <= 0;
        end
        do @(posedge clk_i); while (!bv);
        r = br;
        bry <= 0;
    endtask
    task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_i);
        ara <= ad;
        arv <= 1;
        rry <= 1;
        do @(posedge clk_i); while (!arr);
        arv <= 0;
        do @(posedge clk_i); while (!rv);
        d = rdt;
        r = rr;
        rry <= 0;
    endtask
    // Random operations; the reference read expectation is sometimes the stored word
    task automatic run_ops(input int n);
        int left;
        mpb_pkg::mpb_cyc_type c;
        logic [13:0] sv;
        left = 0;
        repeat (n) begin
            @(posedge clk_i);
            c = '0;
            c.op_active = 1;
            c.first_cycle = (left == 0);
            if (left == 0) left = 1 + $urandom % 5;
            left--;
            for (int i = 0; i < 7; i++) sv[2*i+:2] = 2'($urandom % 3);
            c.sel = sv;
            {c.row, c.col, c.wdata, c.strobe} = 26'($urandom);
            c.expect_data = ($urandom % 2) ? sh[{c.row, c.col}] : 16'($urandom);
            cyc <= c;
            func <= 27'($urandom);
        end
        @(posedge clk_i);
        cyc <= '0;
        func <= '0;
        repeat (4) @(posedge clk_i);
    endtask
    // ======================================================
    // Reference model: resolves each cycle's settings into the expected port
    always @(posedge clk_i) begin
        if (mdl) begin
            if (ep.we) sh[ep.addr] = ep.wdata;
            os = d1s;
            of = d1f;
            d1s = d2s;
            d1f = d2f;
            d2s = 0;
            if (os && of) stk = 1;
            cd = cyc.sel;
            for (int i = 0; i < 7; i++) v[i] = cd[2*i+:2] == `MPB_SET_ON ? 1'b1 :
                cd[2*i+:2] == `MPB_SET_OFF ? 1'b0 : !cyc.first_cycle && hold[i];
            if (cyc.op_active) hold = v;
            wen = cd[11:10] == `MPB_SET_AUTO ? v[2] | v[1] : v[5];
            okt = typ inside {`MPB_MT_2RW, `MPB_MT_1R1W, `MPB_MT_NR2W};
            cw = en_m && cyc.op_active && wen && okt;
            // Read needs only a non-ROM, non-1RW type; other type codes still allow it
            cr = en_m && cyc.op_active && !cw && v[6] && prd && tlp
                && !(typ inside {`MPB_MT_ROM, `MPB_MT_1RW});
            a = {cyc.row, cyc.col};
            if (cw) a = a ^ {5'h00, v[2], 2'h0, v[1]};
            if (cr) a = a ^ {5'h00, v[3] && hrow || v[4] && !hcol, 2'h0, v[4] && hcol};
            pe = !en_m;
            ep = en_m ? {a, cyc.wdata ^ {16{v[0]}}, cw, cr} : func;
            if (cr && cyc.strobe && syn) d2s = 1;
            if (cr && cyc.strobe && syn) d2f = sh[a] !== cyc.expect_data;
            if (cr && cyc.strobe && !syn) d1s = 1;
            if (cr && cyc.strobe && !syn) d1f = sh[a] !== cyc.expect_data;
            vld <= 1;
        end
    end
    // Compare mid-cycle, once every registered output has settled
    always @(negedge clk_i) begin
        if (vld) begin
            cmp_v(32'(pt.we), 32'(ep.we), "we");
            cmp_v(32'(pt.re), 32'(ep.re), "re");
            cmp_v(32'(pt.addr), 32'(ep.addr), "addr");
            if (ep.we || pe) cmp_v(32'(pt.wdata), 32'(ep.wdata), "wdata");
            cmp_v(32'(cs), 32'(os), "strobe");
            cmp_v(32'(cf), 32'(os && of), "fail");
        end
    end
    // ======================================================
    // Main sequence and watchdog
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        void'($urandom(54941));
        for (int i = 0; i < 512; i++) sh[i] = 16'(i * 16'h0F1D) ^ 16'hA5C3;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1;
        repeat (2) @(posedge clk_i);
        mdl <= 1;
        axi_rd(`MPB_OFS_CTRL, d, r);
        cmp_v(d, `MPB_CTRL_RST, "ctrl reset");
        axi_rd(`MPB_OFS_CFG, d, r);
        cmp_v(d, `MPB_CFG_RST, "cfg reset");
        axi_rd(8'h0C, d, r);
        cmp_v(d, 32'h0000_0000, "unmapped read data");
        cmp_v(32'(r), 32'(`MPB_RESP_SLVERR), "unmapped read resp");
        axi_wr(8'h10, 32'hFFFF_FFFF, r);
        cmp_v(32'(r), 32'(`MPB_RESP_SLVERR), "unmapped write");
        for (int k = 0; k < 14; k++) begin
            d = ($urandom & 32'hF8) | (k % 6);
            axi_wr(`MPB_OFS_CFG, d, r);
            {syn, tlp, prd, hrow, hcol, typ} <= d[7:0];
            axi_rd(`MPB_OFS_CFG, d, r);
            cmp_v(32'(d[7:0]), 32'({syn, tlp, prd, hrow, hcol, typ}), "cfg");
            axi_wr(`MPB_OFS_CTRL, 32'(k % 4 != 3), r);
            en_m <= (k % 4 != 3);
            run_ops(40);
            axi_rd(`MPB_OFS_STAT, d, r);
            cmp_v(32'(d[1:0]), 32'({1'b0, stk}), "stat");
            axi_wr(`MPB_OFS_STAT, 32'h1, r);
            stk <= 0;
        end
        results();
    end
    initial begin
        #200000;
        fail_count++;
        results();
    end
endmodule
